// ===== hdl/oss_map.svh
// Purpose: Offsets, field positions, reset values, function codes and timing counts
//          for the output signal selector.
// Assumes: Included by the package, oss_top and the bench by its bare name.
// Notes:   Definitions only.
`ifndef OSS_MAP_SVH
`define OSS_MAP_SVH

// Register byte offsets on the AHB-Lite bus
`define OSS_OFF_CODE0        8'h00
`define OSS_OFF_CODE1        8'h04
`define OSS_OFF_CODE2        8'h08
`define OSS_OFF_CODE3        8'h0c
`define OSS_OFF_CUR_HI_THR   8'h10
`define OSS_OFF_CUR_HI_TIME  8'h14
`define OSS_OFF_ZERO_THR     8'h18
`define OSS_OFF_ZERO_TIME    8'h1c
`define OSS_OFF_PID_LO       8'h20
`define OSS_OFF_PID_HI       8'h24
`define OSS_OFF_HS_TRIP      8'h28
`define OSS_OFF_LOW_SPD      8'h2c
`define OSS_OFF_TORQUE_THR   8'h30
`define OSS_OFF_POS_WIDTH    8'h34
`define OSS_OFF_CTRL         8'h38
`define OSS_OFF_FLAGS_LO     8'h3c
`define OSS_OFF_FLAGS_HI     8'h40

// Control and flags register fields
`define OSS_CTRL_BRAKE_EN    0
`define OSS_CTRL_ORIENT_EN   1
`define OSS_CTRL_MODE_LSB    2
`define OSS_CTRL_MODE_MSB    3
`define OSS_FLAGS_HI_TERM    16

// Reset values
`define OSS_RST_CODE         9'h000
`define OSS_RST_THR          16'h0000
`define OSS_RST_CTRL         4'h0

// Function code ranges (0-99 and 200-299 positive, 100-199 and 300-399 inverted)
`define OSS_CODE_NEG_LO      9'h064
`define OSS_CODE_POS2_LO     9'h0c8
`define OSS_CODE_NEG2_LO     9'h12c
`define OSS_CODE_END         9'h190
`define OSS_CODE_NONE        9'h1ff
`define OSS_FN_COUNT         9'h028

// Function numbers (positive-polarity codes)
`define OSS_FN_CUR_HI        6'h0c
`define OSS_FN_ZERO_CUR      6'h0d
`define OSS_FN_PID_LO        6'h0e
`define OSS_FN_PID_HI        6'h0f
`define OSS_FN_BYP_B         6'h12
`define OSS_FN_BYP_C         6'h13
`define OSS_FN_BRAKE         6'h14
`define OSS_FN_STROKE        6'h18
`define OSS_FN_FAN           6'h19
`define OSS_FN_HS_PRE        6'h1a
`define OSS_FN_ORIENT_DONE   6'h1b
`define OSS_FN_ORIENT_FAULT  6'h1c
`define OSS_FN_FWD           6'h1e
`define OSS_FN_REV           6'h1f
`define OSS_FN_REGEN         6'h20
`define OSS_FN_READY2        6'h21
`define OSS_FN_LOW_SPD       6'h22
`define OSS_FN_TORQUE        6'h23
`define OSS_FN_IN_POS        6'h24
`define OSS_FN_TRAVEL        6'h26
`define OSS_FN_TUNED         6'h27

// Which function numbers exist, and which have no inverted code
`define OSS_FN_DEFINED       40'hdf_df1c_f000
`define OSS_FN_NO_INV        40'h00_000c_0000

// Heat sink prealarm at 85 percent of the trip temperature
`define OSS_HS_PCT           8'h55
`define OSS_HS_FULL          8'h64

// Detection time base: one tick per millisecond at a 5 ns clock
`define OSS_CLK_PERIOD_NS    32'h0000_0005
`define OSS_TICK_NS          32'h000f_4240
`define OSS_TICK_CYCLES      (`OSS_TICK_NS / `OSS_CLK_PERIOD_NS)

`define OSS_TERMS            4

`endif

// ===== hdl/oss_pkg.sv
// Purpose: Types shared by the output signal selector modules.
// Assumes: oss_map.svh holds the numbers.
// Notes:   Types only.
`include "oss_map.svh"

package oss_pkg;

   typedef logic [8:0]  oss_code_t;
   typedef logic [15:0] oss_word_t;
   typedef logic [39:0] oss_fvec_t;

   // Drive control method, selects which flags are meaningful
   typedef enum logic [1:0] {
      OSS_MODE_VF       = 2'b00,
      OSS_MODE_SENSLESS = 2'b01,
      OSS_MODE_VECTOR   = 2'b10,
      OSS_MODE_PM       = 2'b11
   } oss_mode_t;

endpackage

// ===== hdl/oss_qual_if.sv
// Purpose: Carries one condition, its time limit and the qualified result.
// Assumes: One clock domain.
// Notes:   drv side is the selector top, qual side the timer.
`timescale 1ns/10ps

interface oss_qual_if;
   logic        cond;
   logic        tick;
   logic [15:0] limit;
   logic        met;

   modport drv  (output cond, output tick, output limit, input met);
   modport qual (input cond, input tick, input limit, output met);
endinterface

// ===== hdl/oss_time_qual.sv
// Purpose: Qualifies a level by requiring it to hold for a minimum time.
// Assumes: tick is a one-cycle pulse once per millisecond.
// Notes:   The first tick may fall anywhere in the first millisecond.
`timescale 1ns/10ps

module oss_time_qual
   import oss_pkg::*;
   (
   input wire logic   clk_sys,
   input wire logic   rst,
   oss_qual_if.qual   q
   );

   logic [15:0] held_ms;

   // Count whole ticks while the level holds; a drop restarts the wait
   always_ff @(posedge clk_sys) begin
      if (rst || !q.cond) begin
         held_ms <= 16'h0000;
      end else if (q.tick && held_ms != 16'hffff) begin
         held_ms <= held_ms + 16'h0001;
      end
   end

   // Saturating count avoids wrap on very long holds
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q.met <= 1'b0;
      end else begin
         q.met <= q.cond && (held_ms >= q.limit);
      end
   end

endmodule

// ===== hdl/oss_top.sv
// Purpose: Output signal selector; builds drive status flags and routes one
//          of them to each output terminal by a function code.
// Assumes: Drive condition inputs come from logic on clk_sys; stroke-end and
//          fan-fault inputs are pins and are synchronised here.
// Notes:   Registers on AHB-Lite, word accesses, zero wait states except a
//          read that directly follows a write.
// What this block does
// - Code 12/112: current above threshold for at least detection time.
// - Code 13/113: current below zero-current threshold for at least detection time.
// - Code 14/114: PID input below lower limit.
// - Code 15/115: PID input above upper limit.
// - Codes 18 and 19: bypass contactor drives, positive polarity only.
// - Code 20/120: brake release request, only with brake sequence enabled.
// - Code 24/124: forward or reverse stroke-end input active.
// - Code 25/125: cooling fan fault detected.
// - Code 26/126: heat sink at 85 percent of overheat trip temperature.
// - Codes 27/28: orientation done and fault, only with orientation enabled.
// - Code 30/130: motor rotating forward.
// - Code 31/131: motor rotating in reverse.
// - Code 32/132: regenerating under closed-loop vector control.
// - Code 33/133: pre-excitation or running under any method other than V/f.
// - Code 34/134: output frequency at or below low-speed threshold.
// - Code 35/135: torque above torque threshold.
// - Code 36/136: droop pulses at or below positioning width.
// - Code 38/138: position command done and droop within width.
// - Code 39/139: start-time tuning completed.
// - Codes 0-99, 200-299 positive; 100-199, 300-399 inverted.
`timescale 1ns/10ps
`include "oss_map.svh"

module oss_top
   import oss_pkg::*;
   #(
   parameter int unsigned TICK_CYCLES = `OSS_TICK_CYCLES
   )
   (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Drive conditions, same clock
   input  wire logic [15:0]             out_current,
   input  wire logic [15:0]             pid_value,
   input  wire logic [15:0]             heatsink_temp,
   input  wire logic [15:0]             out_freq,
   input  wire logic [15:0]             motor_torque,
   input  wire logic [15:0]             droop_pulses,
   input  wire logic                    brake_release_cmd,
   input  wire logic                    bypass_b_cmd,
   input  wire logic                    bypass_c_cmd,
   input  wire logic                    orient_done_in,
   input  wire logic                    orient_fault_in,
   input  wire logic                    motor_fwd,
   input  wire logic                    motor_rev,
   input  wire logic                    regen_in,
   input  wire logic                    pre_excite,
   input  wire logic                    running_normal,
   input  wire logic                    pos_cmd_done,
   input  wire logic                    tuning_complete_in,
   // Pins from outside the clock domain
   input  wire logic                    fwd_stroke_end_in,
   input  wire logic                    rev_stroke_end_in,
   input  wire logic                    fan_fault_in,
   // Output terminals
   output logic [`OSS_TERMS-1:0]        term_out
   );

   // Registers
   oss_code_t    term_code [`OSS_TERMS];
   oss_word_t    cur_hi_thr;
   oss_word_t    cur_hi_time;
   oss_word_t    zero_thr;
   oss_word_t    zero_time;
   oss_word_t    pid_lo;
   oss_word_t    pid_hi;
   oss_word_t    hs_trip;
   oss_word_t    low_spd_thr;
   oss_word_t    torque_thr;
   oss_word_t    pos_width;
   logic [3:0]   ctrl;
   oss_fvec_t    flags;

   // Bus state
   logic         wr_pend;
   logic [7:0]   wr_addr;
   logic         rd_stall;
   logic [7:0]   rd_addr;
   logic         take;

   // Internal signals
   logic [31:0]  tick_cnt;
   logic         tick;
   logic [2:0]   pin_s1;
   logic [2:0]   pin_s2;
   oss_fvec_t    fvec;
   logic [1:0]   qual_cond;
   logic [1:0]   qual_met;
   oss_word_t    qual_limit [2];
   logic         brake_seq_en;
   logic         orient_en;
   oss_mode_t    mode;
   logic [23:0]  hs_scaled;
   logic [23:0]  hs_limit;

   assign brake_seq_en = ctrl[`OSS_CTRL_BRAKE_EN];
   assign orient_en    = ctrl[`OSS_CTRL_ORIENT_EN];
   assign mode         = oss_mode_t'(ctrl[`OSS_CTRL_MODE_MSB:`OSS_CTRL_MODE_LSB]);
   assign take         = hsel && htrans[1] && hready;

   // Read multiplexer, used for normal and stalled reads
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         `OSS_OFF_CODE0:       w = {23'h00_0000, term_code[0]};
         `OSS_OFF_CODE1:       w = {23'h00_0000, term_code[1]};
         `OSS_OFF_CODE2:       w = {23'h00_0000, term_code[2]};
         `OSS_OFF_CODE3:       w = {23'h00_0000, term_code[3]};
         `OSS_OFF_CUR_HI_THR:  w = {16'h0000, cur_hi_thr};
         `OSS_OFF_CUR_HI_TIME: w = {16'h0000, cur_hi_time};
         `OSS_OFF_ZERO_THR:    w = {16'h0000, zero_thr};
         `OSS_OFF_ZERO_TIME:   w = {16'h0000, zero_time};
         `OSS_OFF_PID_LO:      w = {16'h0000, pid_lo};
         `OSS_OFF_PID_HI:      w = {16'h0000, pid_hi};
         `OSS_OFF_HS_TRIP:     w = {16'h0000, hs_trip};
         `OSS_OFF_LOW_SPD:     w = {16'h0000, low_spd_thr};
         `OSS_OFF_TORQUE_THR:  w = {16'h0000, torque_thr};
         `OSS_OFF_POS_WIDTH:   w = {16'h0000, pos_width};
         `OSS_OFF_CTRL:        w = {28'h000_0000, ctrl};
         `OSS_OFF_FLAGS_LO:    w = flags[31:0];
         `OSS_OFF_FLAGS_HI:    w = {12'h000, term_out, 8'h00, flags[39:32]};
         default:              w = 32'h0000_0000;   // Unmapped reads as zero
      endcase
      return w;
   endfunction

   // Code decode: polarity and function number, then pick the flag
   function automatic logic term_level(input oss_code_t code, input oss_fvec_t fv);
      oss_code_t fn;
      logic      inv;
      logic      defined;
      oss_fvec_t def_v;
      fn  = `OSS_CODE_NONE;
      inv = 1'b0;
      def_v = `OSS_FN_DEFINED;
      if (code < `OSS_CODE_NEG_LO) begin
         fn = code;
      end else if (code < `OSS_CODE_POS2_LO) begin
         fn  = code - `OSS_CODE_NEG_LO;
         inv = 1'b1;
      end else if (code < `OSS_CODE_NEG2_LO) begin
         fn = code - `OSS_CODE_POS2_LO;
      end else if (code < `OSS_CODE_END) begin
         fn  = code - `OSS_CODE_NEG2_LO;
         inv = 1'b1;
      end
      defined = 1'b0;
      if (fn < `OSS_FN_COUNT) begin
         defined = def_v[fn[5:0]];
         // Bypass contactor drives have no inverted code
         if (inv && ((`OSS_FN_NO_INV >> fn[5:0]) & 40'h00_0000_0001) != 40'h0) begin
            defined = 1'b0;
         end
      end
      // Positive flag, inverted for inverted codes, or inactive when undefined
      return defined ? (fv[fn[5:0]] ^ inv) : 1'b0;
   endfunction

   // Address phase capture; a read right after a write waits one cycle so
   // that it returns the freshly written value instead of a stale one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         rd_stall  <= 1'b0;
         rd_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= take && hwrite;
         if (take && hwrite) begin
            wr_addr <= haddr[7:0];
         end
         if (take && !hwrite && wr_pend) begin
            rd_stall  <= 1'b1;
            rd_addr   <= (haddr[31:8] != 24'h00_0000) ? 8'hff : haddr[7:0];   // Unmapped, reads zero
            hreadyout <= 1'b0;
         end else if (rd_stall) begin
            rd_stall  <= 1'b0;
            hrdata    <= rd_word(rd_addr);
            hreadyout <= 1'b1;
         end else if (take && !hwrite) begin
            hrdata <= rd_word(haddr[7:0]);
         end
         if (haddr[31:8] != 24'h00_0000 && take && !hwrite && !wr_pend) begin
            hrdata <= 32'h0000_0000;   // Outside the block's window
         end
      end
   end

   // Register writes in the data phase; only whole words are expected
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < `OSS_TERMS; i++) begin
            term_code[i] <= `OSS_RST_CODE;
         end
         cur_hi_thr  <= `OSS_RST_THR;
         cur_hi_time <= `OSS_RST_THR;
         zero_thr    <= `OSS_RST_THR;
         zero_time   <= `OSS_RST_THR;
         pid_lo      <= `OSS_RST_THR;
         pid_hi      <= `OSS_RST_THR;
         hs_trip     <= `OSS_RST_THR;
         low_spd_thr <= `OSS_RST_THR;
         torque_thr  <= `OSS_RST_THR;
         pos_width   <= `OSS_RST_THR;
         ctrl        <= `OSS_RST_CTRL;
      end else if (wr_pend) begin
         unique case (wr_addr)
            `OSS_OFF_CODE0:       term_code[0] <= hwdata[8:0];
            `OSS_OFF_CODE1:       term_code[1] <= hwdata[8:0];
            `OSS_OFF_CODE2:       term_code[2] <= hwdata[8:0];
            `OSS_OFF_CODE3:       term_code[3] <= hwdata[8:0];
            `OSS_OFF_CUR_HI_THR:  cur_hi_thr   <= hwdata[15:0];
            `OSS_OFF_CUR_HI_TIME: cur_hi_time  <= hwdata[15:0];
            `OSS_OFF_ZERO_THR:    zero_thr     <= hwdata[15:0];
            `OSS_OFF_ZERO_TIME:   zero_time    <= hwdata[15:0];
            `OSS_OFF_PID_LO:      pid_lo       <= hwdata[15:0];
            `OSS_OFF_PID_HI:      pid_hi       <= hwdata[15:0];
            `OSS_OFF_HS_TRIP:     hs_trip      <= hwdata[15:0];
            `OSS_OFF_LOW_SPD:     low_spd_thr  <= hwdata[15:0];
            `OSS_OFF_TORQUE_THR:  torque_thr   <= hwdata[15:0];
            `OSS_OFF_POS_WIDTH:   pos_width    <= hwdata[15:0];
            `OSS_OFF_CTRL:        ctrl         <= hwdata[3:0];
            default:              ;   // Read-only or unmapped, ignored
         endcase
      end
   end

   // Millisecond tick for the detection timers
   always_ff @(posedge clk_sys) begin
      if (rst || tick) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt == TICK_CYCLES - 32'h0000_0001);

   // Two-stage synchronisers for the asynchronous pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         pin_s1 <= {fan_fault_in, rev_stroke_end_in, fwd_stroke_end_in};
         pin_s2 <= pin_s1;
      end
   end

   // Current detection conditions and their minimum hold times
   assign qual_cond[0]  = out_current > cur_hi_thr;
   assign qual_limit[0] = cur_hi_time;
   assign qual_cond[1]  = out_current < zero_thr;
   assign qual_limit[1] = zero_time;

   oss_qual_if qif [2] ();

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_qual
         assign qif[g].cond  = qual_cond[g];
         assign qif[g].tick  = tick;
         assign qif[g].limit = qual_limit[g];
         assign qual_met[g]  = qif[g].met;
         oss_time_qual u_qual (
            .clk_sys (clk_sys),
            .rst     (rst),
            .q       (qif[g])
         );
      end
   endgenerate

   // Heat sink compare by cross multiplication avoids a divider
   assign hs_scaled = 24'(heatsink_temp) * 24'(`OSS_HS_FULL);
   assign hs_limit  = 24'(hs_trip) * 24'(`OSS_HS_PCT);

   // Flag vector indexed by function number
   always_comb begin
      fvec = 40'h00_0000_0000;
      fvec[`OSS_FN_CUR_HI]       = qual_met[0];
      fvec[`OSS_FN_ZERO_CUR]     = qual_met[1];
      fvec[`OSS_FN_PID_LO]       = pid_value < pid_lo;
      fvec[`OSS_FN_PID_HI]       = pid_value > pid_hi;
      fvec[`OSS_FN_BYP_B]        = bypass_b_cmd;
      fvec[`OSS_FN_BYP_C]        = bypass_c_cmd;
      fvec[`OSS_FN_BRAKE]        = brake_seq_en && brake_release_cmd;
      fvec[`OSS_FN_STROKE]       = pin_s2[0] || pin_s2[1];
      fvec[`OSS_FN_FAN]          = pin_s2[2];
      fvec[`OSS_FN_HS_PRE]       = hs_scaled >= hs_limit;
      fvec[`OSS_FN_ORIENT_DONE]  = orient_en && orient_done_in;
      fvec[`OSS_FN_ORIENT_FAULT] = orient_en && orient_fault_in;
      fvec[`OSS_FN_FWD]          = motor_fwd;
      fvec[`OSS_FN_REV]          = motor_rev;
      fvec[`OSS_FN_REGEN]        = regen_in && (mode == OSS_MODE_VECTOR);
      fvec[`OSS_FN_READY2]       = (pre_excite || running_normal)
                                   && (mode != OSS_MODE_VF);
      fvec[`OSS_FN_LOW_SPD]      = out_freq <= low_spd_thr;
      fvec[`OSS_FN_TORQUE]       = motor_torque > torque_thr;
      fvec[`OSS_FN_IN_POS]       = droop_pulses <= pos_width;
      fvec[`OSS_FN_TRAVEL]       = pos_cmd_done && (droop_pulses <= pos_width);
      fvec[`OSS_FN_TUNED]        = tuning_complete_in;
   end

   // Flag snapshot for software
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flags <= 40'h00_0000_0000;
      end else begin
         flags <= fvec;
      end
   end

   // Terminal outputs, registered so external equipment sees clean levels
   generate
      for (g = 0; g < `OSS_TERMS; g++) begin : g_term
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               term_out[g] <= 1'b0;
            end else begin
               term_out[g] <= term_level(term_code[g], fvec);
            end
         end
      end
   endgenerate

endmodule

// ===== testbench/oss_top_asserts.sv
// Purpose: Bus and terminal checks on the oss_top ports.
// Assumes: One clock; rst synchronous, active high.
// Notes:   The bind follows the checker module.
`timescale 1ns/10ps

module oss_top_chk
   (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [3:0]  term_out
   );
   logic rd_take;
   logic wr_take;
   logic wr_d;

   // Transfers taken at this edge
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign wr_take = hsel && htrans[1] && hready && hwrite;

   // A write data phase stalls the read behind it, so such reads are left out below
   always_ff @(posedge clk_sys) begin
      wr_d <= !rst && wr_take;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_stall_one: assert property (!hreadyout |=> hreadyout)
      else $error("stall longer than one cycle");
   a_stall_cause: assert property (!hreadyout |-> $past(rd_take) && $past(wr_take, 2))
      else $error("stall without a read after a write");
   a_write_nostall: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   a_reset_clear: assert property ($fell(rst) |-> term_out == '0 && hrdata == '0)
      else $error("outputs not cleared by reset");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_take) || $past(rd_take, 2))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (rd_take && haddr[31:8] != '0 && !wr_d |=> hrdata == '0)
      else $error("unmapped read not zero");
   a_code_narrow: assert property (rd_take && haddr[7:4] == '0 && !wr_d |=> hrdata[31:9] == '0)
      else $error("code register upper bits not zero");

   c_term_on: cover property (term_out != '0);
   c_term_all: cover property (term_out == 4'hf);
   c_unmapped: cover property (rd_take && haddr[31:8] != '0);
endmodule

bind oss_top oss_top_chk i_oss_top_chk (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .hreadyout, .hresp, .term_out);

// ===== testbench/oss_term_reader.sv
// Purpose: External equipment reading the output terminals.
// Assumes: It samples the terminals on clk_sys.
// Notes:   Adds one cycle of lag, which the bench allows for.
`timescale 1ns/10ps

module oss_term_reader
   (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [3:0] term_out,
   output logic      [3:0] seen
   );
   // A reading input registers each level once
   always_ff @(posedge clk_sys) begin
      seen <= rst ? 4'h0 : term_out;
   end
endmodule

// ===== testbench/oss_top_tb.sv
// Purpose: Self-checking bench for oss_top.
// Assumes: TICK_CYCLES of 10, so one ms is ten cycles.
// Notes:   Every function runs in all four code ranges at once.
`timescale 1ns/10ps
`include "oss_map.svh"

module oss_top_tb;
   logic        clk_sys, rst, hwrite, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [15:0] cur, pid, hst, frq, trq, drp;
   logic [14:0] lv;
   logic [3:0]  term_out, seen;
   logic [23:0] page;
   int          n_errors, checks_done, cyc, fn;
   int          fns [21] = '{12, 13, 14, 15, 18, 19, 20, 24, 25, 26, 27, 28, 30, 31, 32, 33, 34,
                             35, 36, 38, 39};
   int          gfn [4] = '{20, 27, 32, 33};
   int          ufn [4] = '{24, 116, 400, 329};
   logic [15:0] cfg [11] = '{16'h0064, 16'h0002, 16'h000a, 16'h0002, 16'h0032, 16'h00c8,
                             16'h0064, 16'h001e, 16'h0028, 16'h0005, 16'h000b};

   oss_top #(.TICK_CYCLES(10)) i_oss_top (.clk_sys(clk_sys), .rst(rst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .out_current(cur), .pid_value(pid), .heatsink_temp(hst), .out_freq(frq),
      .motor_torque(trq), .droop_pulses(drp), .brake_release_cmd(lv[0]),
      .bypass_b_cmd(lv[1]), .bypass_c_cmd(lv[2]), .orient_done_in(lv[3]),
      .orient_fault_in(lv[4]), .motor_fwd(lv[5]), .motor_rev(lv[6]), .regen_in(lv[7]),
      .pre_excite(lv[8]), .running_normal(lv[9]), .pos_cmd_done(lv[10]),
      .tuning_complete_in(lv[11]), .fwd_stroke_end_in(lv[12]), .rev_stroke_end_in(lv[13]),
      .fan_fault_in(lv[14]), .term_out(term_out));
   oss_term_reader i_oss_term_reader (.clk_sys(clk_sys), .rst(rst), .term_out(term_out),
      .seen(seen));

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Address phase held until hready, then the data phase until hready again
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr  <= {page, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      if (w) hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0000_0000);
   endtask

   task automatic chk_term(input logic [3:0] got, input logic [3:0] want);
      checks_done++;
      if (got !== want) begin
         n_errors++;
         $display("[FAIL] %0t terminals %h, expected %h", $time, got, want);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         n_errors++;
         $display("[FAIL] %0t read %h, expected %h", $time, got, want);
      end
   endtask

   // Codes 18 and 19 have no inverted form, so 118 and 318 stay inactive
   function automatic logic [3:0] exp_term(input logic f, input int n);
      logic nf;
      nf = (n == 18 || n == 19) ? 1'b0 : !f;
      return {nf, f, nf, f};
   endfunction

   // Drives the condition behind one function; idle values sit just off the heat sink, frequency, torque and droop thresholds
   task automatic set_cond(input int n, input logic on);
      case (n)
         12: cur <= on ? 16'h00c8 : 16'h0032;
         13: cur <= on ? 16'h0005 : 16'h0032;
         14: pid <= on ? 16'h0031 : 16'h0064;
         15: pid <= on ? 16'h00c9 : 16'h0064;
         26: hst <= on ? 16'h0055 : 16'h0054;
         34: frq <= on ? 16'h001e : 16'h001f;
         35: trq <= on ? 16'h0029 : 16'h0028;
         36: drp <= on ? 16'h0005 : 16'h0006;
         38: begin drp <= 16'h0005; lv[10] <= on; end
         18: lv[1] <= on;  19: lv[2] <= on;  20: lv[0] <= on;  24: lv[12] <= on;
         25: lv[14] <= on; 27: lv[3] <= on;  28: lv[4] <= on;  30: lv[5] <= on;
         31: lv[6] <= on;  32: lv[7] <= on;  33: lv[8] <= on;  39: lv[11] <= on;
         default: ;
      endcase
   endtask

   task automatic give_verdict();
      $display("checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard, well above the roughly 2100 cycles the sequence needs
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         n_errors++;
         $display("[FAIL] %0t run did not finish", $time);
         give_verdict();
      end
   end

   initial begin
      rst = 1'b1; htrans = 2'b00; hwrite = 1'b0; haddr = '0; hwdata = '0; page = '0; lv = '0;
      cur = 16'h0032; pid = 16'h0064; hst = 16'h0054; frq = 16'h001f; trq = 16'h0028;
      drp = 16'h0006; n_errors = 0; checks_done = 0; cyc = 0;
      tick(6);
      rst <= 1'b0;
      tick(1);
      rd(`OSS_OFF_CODE0);
      chk_word(rdat, 32'h0000_0000);
      chk_term(seen, 4'h0);
      foreach (cfg[i]) wr(8'h10 + 8'(4 * i), {16'h0000, cfg[i]});
      rd(`OSS_OFF_CTRL);
      chk_word(rdat, 32'h0000_000b);
      page = 24'h00_0001;
      rd(`OSS_OFF_CODE0);
      chk_word(rdat, 32'h0000_0000);
      page = 24'h00_0000;
      rd(8'h44);
      chk_word(rdat, 32'h0000_0000);
      // Positive and inverted codes per function; current flags must wait out their time
      foreach (fns[k]) begin
         fn = fns[k];
         for (int t = 0; t < 4; t++) wr(8'(4 * t), 32'(fn + 100 * t));
         set_cond(fn, 1'b0);
         tick(30);
         chk_term(seen, exp_term(1'b0, fn));
         set_cond(fn, 1'b1);
         tick(6);
         if (fn < 14) chk_term(seen, exp_term(1'b0, fn));
         tick(40);
         chk_term(seen, exp_term(1'b1, fn));
         rd(`OSS_OFF_FLAGS_LO);
         if (fn < 32) chk_word(rdat & (32'h1 << fn), 32'h1 << fn);
         rd(`OSS_OFF_FLAGS_HI);
         chk_word(rdat & 32'h000f_0000, {12'h000, exp_term(1'b1, fn), 16'h0000});
         if (fn >= 32) chk_word(rdat & (32'h1 << (fn - 32)), 32'h1 << (fn - 32));
         set_cond(fn, 1'b0);
      end
      // Enables and control mode gate brake, orientation, regen and ready-2
      for (int t = 0; t < 4; t++) wr(8'(4 * t), 32'(gfn[t]));
      lv <= 15'h7fff;
      wr(`OSS_OFF_CTRL, 32'h0000_0000);
      tick(30);
      chk_term(seen, 4'h0);
      wr(`OSS_OFF_CTRL, 32'h0000_000b);
      tick(30);
      chk_term(seen, 4'hf);
      // Open-loop vector and PM modes keep ready-2 but not regeneration
      wr(`OSS_OFF_CTRL, 32'h0000_0007);
      tick(30);
      chk_term(seen, 4'hb);
      wr(`OSS_OFF_CTRL, 32'h0000_000f);
      tick(30);
      chk_term(seen, 4'hb);
      // Undefined codes stay low even when inverted; reverse stroke end alone warns
      foreach (ufn[t]) wr(8'(4 * t), 32'(ufn[t]));
      lv <= 15'h2000;
      tick(30);
      chk_term(seen, 4'h1);
      give_verdict();
   end
endmodule
